// ===== include/gns_regs.vh
// Opcodes, field widths and latencies for the guarded negate/compare/subtract unit
// Contract
// - Negate writes two's complement of source, latency one
// - Most negative value negates to itself
// - Negate is subtract from zero register
// - Guard bit 0 clear leaves destination unchanged
// - Register not-equal compare writes one or zero
// - Immediate not-equal compare, 7-bit modifier, opcode 3
// - Immediate sign-extended, both operands signed
// - Select zero if first source nonzero
// - Subtract first minus second, opcode 13
// - Subtract wraps silently, no overflow flag
// - Any nonzero pattern, negative included, counts
// - Multiply-high returns upper product half, latency three
`ifndef GNS_REGS_VH
`define GNS_REGS_VH
`define GNS_OPC_W 8
`define GNS_OPC_INEQI 8'h03
`define GNS_OPC_ISUB 8'h0d
`define GNS_OPC_INEQ 8'h27
`define GNS_OPC_INONZERO 8'h2f
`define GNS_OPC_IMULM 8'h8b
`define GNS_IMM_W 7
`define GNS_REG_ADDR_W 7
`define GNS_ALU_LAT 1
`define GNS_MUL_LAT 3
`endif

// ===== logic/gns_unit.v
// Guarded integer datapath: subtract/negate, not-equal compares, select, multiply-high
`timescale 1ns/1ps
`include "gns_regs.vh"
module gns_unit (
    input wire clk,
    input wire rst,
    input wire issueValid,
    input wire [`GNS_OPC_W-1:0] opcode,
    input wire [`GNS_IMM_W-1:0] modifier,
    input wire [31:0] firstSourceReg,
    input wire [31:0] secondSourceReg,
    input wire guardPresent,
    input wire [31:0] guardReg,
    input wire [`GNS_REG_ADDR_W-1:0] destAddr,
    output reg resultWrite,
    output reg [`GNS_REG_ADDR_W-1:0] resultAddr,
    output reg [31:0] resultData,
    output reg mulWrite,
    output reg [`GNS_REG_ADDR_W-1:0] mulAddr,
    output reg [31:0] mulData
);

    // Widths used across the unit
    localparam DW = 32;
    localparam AW = `GNS_REG_ADDR_W;
    localparam IW = `GNS_IMM_W;

    // Multiply stage words: valid, destination, then data
    localparam MUL_A_W = 1 + AW + 2 * DW;
    localparam MUL_B_W = 1 + AW + DW;

    // Operation decode, one flag per supported opcode
    wire isSub;
    wire isNeq;
    wire isNeqImm;
    wire isSelZero;
    wire isMulHigh;
    wire aluHit;
    assign isSub = (opcode == `GNS_OPC_ISUB);
    assign isNeq = (opcode == `GNS_OPC_INEQ);
    assign isNeqImm = (opcode == `GNS_OPC_INEQI);
    assign isSelZero = (opcode == `GNS_OPC_INONZERO);
    assign isMulHigh = (opcode == `GNS_OPC_IMULM);

    // Unknown opcodes fall through and never raise a write strobe
    assign aluHit = isSub | isNeq | isNeqImm | isSelZero;

    // Guard: bit 0 gates the write; an operation without a guard always writes
    wire guardOk;
    wire aluTake;
    wire mulTake;
    assign guardOk = guardPresent ? guardReg[0] : 1'b1;
    assign aluTake = issueValid & aluHit & guardOk;
    assign mulTake = issueValid & isMulHigh & guardOk;

    // Subtract as first plus inverted second plus one, kept to one word
    // No carry is formed, so results wrap and no overflow flag exists
    wire [DW-1:0] secondInv;
    wire [DW-1:0] diff;
    assign secondInv = ~secondSourceReg;
    assign diff = firstSourceReg + secondInv + 32'h00000001;

    // Negate has no path of its own: the issuer sends the zero register
    // as first source, so diff is the two's complement of the second
    // source, and the most negative value comes back unchanged

    // Immediate: seven-bit signed modifier stretched over the full word
    wire [DW-1:0] immExt;
    assign immExt = {{(DW-IW){modifier[IW-1]}}, modifier};

    // Not-equal results and the zero test on the first source
    wire srcDiffer;
    wire immDiffer;
    wire firstNonZero;
    assign srcDiffer = (firstSourceReg != secondSourceReg);
    assign immDiffer = (firstSourceReg != immExt);
    assign firstNonZero = |firstSourceReg;

    // Alu result choice for the operation now on the issue port
    reg [DW-1:0] nxt_data;
    always @* begin
        nxt_data = {DW{1'b0}};
        case (opcode)
            `GNS_OPC_ISUB: begin
                nxt_data = diff;
            end
            `GNS_OPC_INEQ: begin
                nxt_data = {{(DW-1){1'b0}}, srcDiffer};
            end
            `GNS_OPC_INEQI: begin
                nxt_data = {{(DW-1){1'b0}}, immDiffer};
            end
            `GNS_OPC_INONZERO: begin
                if (firstNonZero) begin
                    nxt_data = {DW{1'b0}};
                end else begin
                    nxt_data = secondSourceReg;
                end
            end
            default: begin
                nxt_data = {DW{1'b0}};
            end
        endcase
    end

    // Alu result register: strobe, address and data one cycle after issue
    // Address and data follow every cycle; only the strobe marks a write
    always @(posedge clk) begin
        if (rst) begin
            resultWrite <= 1'b0;
            resultAddr <= {AW{1'b0}};
            resultData <= {DW{1'b0}};
        end else begin
            resultWrite <= aluTake;
            resultAddr <= destAddr;
            resultData <= nxt_data;
        end
    end

    // Multiply stage A: capture the operands with destination and valid
    wire [MUL_A_W-1:0] mulAIn;
    wire [MUL_A_W-1:0] mulAOut;
    assign mulAIn = {mulTake, destAddr, firstSourceReg, secondSourceReg};

    gns_pipe_stage #(
        .WIDTH(MUL_A_W)
    ) mulStageA (
        .clk(clk),
        .rst(rst),
        .stageIn(mulAIn),
        .stageOut(mulAOut)
    );

    // Stage A fields
    wire mulAValid;
    wire [AW-1:0] mulAAddr;
    wire [DW-1:0] mulAFirst;
    wire [DW-1:0] mulASecond;
    assign mulAValid = mulAOut[MUL_A_W-1];
    assign mulAAddr = mulAOut[MUL_A_W-2 -: AW];
    assign mulAFirst = mulAOut[2*DW-1 -: DW];
    assign mulASecond = mulAOut[DW-1:0];

    // Full signed product; only its upper half is kept
    wire signed [2*DW-1:0] product;
    wire [DW-1:0] productHigh;
    assign product = $signed(mulAFirst) * $signed(mulASecond);
    assign productHigh = product[2*DW-1:DW];

    // Multiply stage B: upper half with its destination and valid
    wire [MUL_B_W-1:0] mulBIn;
    wire [MUL_B_W-1:0] mulBOut;
    assign mulBIn = {mulAValid, mulAAddr, productHigh};

    gns_pipe_stage #(
        .WIDTH(MUL_B_W)
    ) mulStageB (
        .clk(clk),
        .rst(rst),
        .stageIn(mulBIn),
        .stageOut(mulBOut)
    );

    // Stage B fields
    wire mulBValid;
    wire [AW-1:0] mulBAddr;
    wire [DW-1:0] mulBHigh;
    assign mulBValid = mulBOut[MUL_B_W-1];
    assign mulBAddr = mulBOut[MUL_B_W-2 -: AW];
    assign mulBHigh = mulBOut[DW-1:0];

    // Multiply output register: strobe lands on the third edge after issue
    // A guard-false multiply keeps its valid low all the way down the pipe
    always @(posedge clk) begin
        if (rst) begin
            mulWrite <= 1'b0;
            mulAddr <= {AW{1'b0}};
            mulData <= {DW{1'b0}};
        end else begin
            mulWrite <= mulBValid;
            mulAddr <= mulBAddr;
            mulData <= mulBHigh;
        end
    end
endmodule

// Plain register stage for the multiply pipeline, cleared by reset
module gns_pipe_stage #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] stageIn,
    output reg [WIDTH-1:0] stageOut
);

    // Every bit moves one place down the pipe on each edge
    always @(posedge clk) begin
        if (rst) begin
            stageOut <= {WIDTH{1'b0}};
        end else begin
            stageOut <= stageIn;
        end
    end
endmodule

// ===== sim/gns_unit_sva.sv
// Checker for the guarded datapath unit
`timescale 1ns/1ps
`include "gns_regs.vh"
module gns_unit_sva(input clk, rst, issueValid, guardPresent, resultWrite, mulWrite,
    input [7:0] opcode, input [6:0] modifier, destAddr, resultAddr,
    input [31:0] firstSourceReg, secondSourceReg, guardReg, resultData, mulData);
    // Writing issue, decoded per operation, and each operation's result
    wire g = issueValid && (!guardPresent || guardReg[0]);
    wire s = g && opcode == `GNS_OPC_ISUB, q = g && opcode == `GNS_OPC_INEQ;
    wire i = g && opcode == `GNS_OPC_INEQI, z = g && opcode == `GNS_OPC_INONZERO;
    wire [31:0] a = firstSourceReg, b = secondSourceReg, n = {{25{modifier[6]}}, modifier};
    wire signed [63:0] p = $signed(a) * $signed(b);
    wire [31:0] d = a - b, e = a != b, f = a != n, c = a != 0 ? 0 : b, h = p[63:32];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_sub_val: assert property (s |=> resultWrite && resultData == $past(d))
        else $error("sub");
    a_ineq_val: assert property (q |=> resultData == $past(e)) else $error("ineq");
    a_ineqi_val: assert property (i |=> resultData == $past(f)) else $error("ineqi");
    a_select_val: assert property (z |=> resultData == $past(c)) else $error("sel");
    a_mulh_val: assert property (g && opcode == `GNS_OPC_IMULM
        |-> ##3 mulWrite && mulData == $past(h, 3)) else $error("mulh");
    a_guard_off: assert property (issueValid && !g |=> !resultWrite ##2 !mulWrite)
        else $error("guard");
    a_alu_pulse: assert property (resultWrite |-> $past(s || q || i || z))
        else $error("alu");
    a_dest_follow: assert property (resultWrite |-> resultAddr == $past(destAddr))
        else $error("addr");
    // Main scenarios reached
    cover property (mulWrite);
    cover property (resultWrite && resultData == 32'h80000000);
    cover property (issueValid && !g);
endmodule

// ===== sim/gns_rf_model.sv
// Register file model that takes the unit's alu result write-backs, not the multiply ones
`timescale 1ns/1ps
module gns_rf_model(input clk, input we, input [6:0] wa, input [31:0] wd);
    reg [31:0] regFile_ff [0:127];
    // Result lands one edge after the strobe, never sooner
    always @(posedge clk) begin
        if (we) regFile_ff[wa] <= wd;
    end
endmodule

// ===== sim/gns_unit_tb.sv
// Self-checking bench for the guarded datapath unit
`timescale 1ns/1ps
`include "gns_regs.vh"
module gns_unit_tb;
    reg clk = 0, rst = 1, issueValid = 0, guardPresent = 0;
    reg [7:0] opcode = 0;
    reg [6:0] modifier = 0, destAddr = 7'h50;
    reg [31:0] firstSourceReg = 0, secondSourceReg = 0, guardReg = 0;
    wire resultWrite, mulWrite;
    wire [6:0] resultAddr, mulAddr;
    wire [31:0] resultData, mulData;
    int mismatches = 0, compares = 0;
    // Clock, unit and register file
    always #12.5 clk = ~clk;
    gns_unit uut(.clk(clk), .rst(rst), .issueValid(issueValid), .opcode(opcode),
        .modifier(modifier), .firstSourceReg(firstSourceReg),
        .secondSourceReg(secondSourceReg), .guardPresent(guardPresent),
        .guardReg(guardReg), .destAddr(destAddr), .resultWrite(resultWrite),
        .resultAddr(resultAddr), .resultData(resultData), .mulWrite(mulWrite),
        .mulAddr(mulAddr), .mulData(mulData));
    gns_rf_model rf(.clk(clk), .we(resultWrite), .wa(resultAddr), .wd(resultData));
    // Compare strobe and data, report a mismatch
    task chk(input string w, input [32:0] e, g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask
    // Issue one operation; g is {guard present, guard bit}
    task run(input string w, input [7:0] o, input [31:0] a, b, e, input [1:0] g);
        reg [32:0] v;
        @(posedge clk);
        {issueValid, opcode, firstSourceReg, secondSourceReg} <= {1'b1, o, a, b};
        {modifier, guardPresent, guardReg} <= {b[6:0], g[1], 31'h0, g[0]};
        @(posedge clk);
        issueValid <= 0;
        if (o == `GNS_OPC_IMULM) repeat (2) @(posedge clk);
        #1 v = o == `GNS_OPC_IMULM ? {mulWrite, mulData} : {resultWrite, resultData};
        chk(w, g == 2 ? 33'h0 : {1'b1, e}, v[32] ? v : 33'h0);
        chk({w, " addr"}, 33'h50, {26'h0, (o == `GNS_OPC_IMULM) ? mulAddr : resultAddr});
    endtask
    // Single-cycle operations
    task t_alu;
        run("sub", `GNS_OPC_ISUB, 3, 4, 32'hffffffff, 0);
        run("wrap", `GNS_OPC_ISUB, 32'h80000000, 4, 32'h7ffffffc, 0);
        run("negmin", `GNS_OPC_ISUB, 0, 32'h80000000, 32'h80000000, 0);
        run("neg", `GNS_OPC_ISUB, 0, 32'hffffffff, 1, 0);
        run("ineq", `GNS_OPC_INEQ, 3, 4, 1, 0);
        run("ineq0", `GNS_OPC_INEQ, 32'h1000, 32'h1000, 0, 3);
        run("ineqi3", `GNS_OPC_INEQI, 3, 3, 0, 0);
        run("ineqi", `GNS_OPC_INEQI, 32'hffffffc0, 32'h40, 0, 0);
        run("sel", `GNS_OPC_INONZERO, 32'hffffff00, 5, 0, 0);
        run("sel0", `GNS_OPC_INONZERO, 0, 32'h456789, 32'h456789, 0);
    endtask
    // Guard true writes, guard false keeps the old contents
    task t_guard;
        run("grd1", `GNS_OPC_ISUB, 32'h1000, 32'h100, 32'hf00, 3);
        run("grd0", `GNS_OPC_ISUB, 5, 1, 0, 2);
        @(posedge clk);
        #1 chk("keep", 33'hf00, {1'b0, rf.regFile_ff[7'h50]});
    endtask
    // Three-cycle multiply high half
    task t_mul;
        run("mulh", `GNS_OPC_IMULM, 32'h10001000, 32'hf1100000, 32'hff10ff11, 3);
        run("mulneg", `GNS_OPC_IMULM, 32'hffffff00, 32'h64, 32'hffffffff, 0);
    endtask
    // Counts and verdict
    task finish_test;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Main sequence after three reset cycles
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        t_alu;
        t_guard;
        t_mul;
        finish_test;
    end
    // Watchdog against a hang
    initial begin
        #20000;
        mismatches++;
        finish_test;
    end
endmodule
bind gns_unit gns_unit_sva chkr(.clk(clk), .rst(rst), .issueValid(issueValid),
    .guardPresent(guardPresent), .resultWrite(resultWrite), .mulWrite(mulWrite),
    .opcode(opcode), .modifier(modifier), .destAddr(destAddr), .resultAddr(resultAddr),
    .firstSourceReg(firstSourceReg), .secondSourceReg(secondSourceReg),
    .guardReg(guardReg), .resultData(resultData), .mulData(mulData));
